// File: rtl/pmtr_pkg.sv
// Package for the program memory table read block
package pmtr_pkg;
  localparam int PM_DEPTH = 16384;
  localparam int PM_AW = 14;
  localparam int PM_DW = 16;
  localparam logic [13:0] RESET_VECTOR = 14'h0000;
  localparam logic [5:0] LAST_PAGE_HI = 6'h3f;
  localparam int PTR_HI_W = 6;
  localparam int TBL_CYCLES = 2;
  localparam int PROG_BITS = 32;
  localparam logic [7:0] HOLDER_RESET = 8'h00;

  // Instruction variants that the core may issue
  typedef enum logic [1:0] {
    PMTR_RD_PAGED,
    PMTR_RD_LAST
  } pmtr_mode_e;

  // Table read request from the core
  typedef struct packed {
    logic valid;
    logic last_page;
    logic any_sector;
    logic [8:0] dest_addr;
  } pmtr_req_s;

  // Low byte write-back to data memory
  typedef struct packed {
    logic valid;
    logic any_sector;
    logic [8:0] dest_addr;
    logic [7:0] data;
  } pmtr_wb_s;
endpackage

// File: rtl/pmtr_rom.sv
// Program memory array with registered read data
`timescale 1ns/10ps
module pmtr_rom
  import pmtr_pkg::*;
#(
  parameter int DEPTH = PM_DEPTH,
  parameter int AW = PM_AW,
  parameter int DW = PM_DW
) (
  // Clock
  input wire logic sys_clk,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data,
  // Programming write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data
);
  initial begin
    if (DEPTH != (1 << AW)) $error("pmtr_rom: depth must equal 2**AW");
  end

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// File: rtl/pmtr_table_read.sv
// Program memory fetch, table read path and serial programming port
//
// Summary of operation
// - 16K by 16 array serves code and tables
// - Fetch starts at address zero after reset
// - Table address is high pointer then low
// - Low byte goes to operand register
// - High byte loads holder, all eight bits from the array
// - Basic reads sector zero, extended any sector
// - Every table read takes two cycles
// - Holder is software readable and writable
// - Last-page reads ignore high pointer
// - Programming uses one data and clock line
`timescale 1ns/10ps
module pmtr_table_read
  import pmtr_pkg::*;
#(
  parameter int AW = PM_AW
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Instruction fetch
  input wire logic fetch_load,
  input wire logic [AW-1:0] fetch_target,
  input wire logic fetch_step,
  output logic [AW-1:0] fetch_addr,
  output logic [15:0] fetch_word,
  // Table pointers, written by the core
  input wire logic ptr_lo_we,
  input wire logic ptr_hi_we,
  input wire logic [7:0] ptr_wdata,
  output logic [7:0] ptr_lo,
  output logic [7:0] ptr_hi,
  // Table read request and write-back
  input wire pmtr_req_s tbl_req,
  output pmtr_wb_s tbl_wb,
  output logic tbl_busy,
  // Holder register access
  input wire logic holder_we,
  input wire logic [7:0] holder_wdata,
  output logic [7:0] table_high_byte_holder,
  // Serial programming pins
  input wire logic prog_mode,
  input wire logic prog_serial_clock_line,
  input wire logic prog_serial_data_line_in,
  output logic prog_serial_data_line_out,
  output logic prog_serial_data_line_oe_n
);
  initial begin
    if (AW != PM_AW) $error("pmtr_table_read: address width must be %0d", PM_AW);
    if (PROG_BITS != AW + PM_DW + 2 || PROG_BITS > 32 || AW >= PM_DW) begin
      $error("pmtr_table_read: serial frame must be two flag bits, address and data");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} pmtr_state_e;
  pmtr_state_e state_q;
  pmtr_req_s req_q;
  logic [AW-1:0] pc_q;
  logic [AW-1:0] tbl_addr;
  logic [AW-1:0] rom_addr;
  logic [15:0] rom_data;
  logic rom_we;
  logic [AW-1:0] rom_waddr;
  logic [15:0] rom_wdata;
  logic prog_rd_q;
  logic [AW-1:0] prog_addr_q;
  logic [AW-1:0] fetch_pc_q;
  logic fetch_port_q;

  // Paged reads concatenate both pointers, last-page reads force the top page
  assign tbl_addr = tbl_req.last_page ? {LAST_PAGE_HI, ptr_lo} : {ptr_hi[PTR_HI_W-1:0], ptr_lo};
  // Table access steals the port for one cycle; the core stalls fetch meanwhile
  // Serial read-back only borrows the port when no table read is asking
  assign rom_addr = (state_q == ST_IDLE && tbl_req.valid) ? tbl_addr : (prog_rd_q ? prog_addr_q : pc_q);

  pmtr_rom #(.DEPTH(PM_DEPTH), .AW(AW), .DW(PM_DW)) u_rom (
    .sys_clk(sys_clk),
    .rd_addr(rom_addr),
    .rd_data(rom_data),
    .wr_en(rom_we),
    .wr_addr(rom_waddr),
    .wr_data(rom_wdata)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= RESET_VECTOR;
    end else if (fetch_load) begin
      pc_q <= fetch_target;
    end else if (fetch_step && state_q == ST_IDLE && !tbl_req.valid) begin
      pc_q <= pc_q + 14'h0001;
    end
  end

  // Word and address must come from the same port cycle, so the address is delayed with the array
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_pc_q <= RESET_VECTOR;
      fetch_port_q <= 1'b0;
    end else begin
      fetch_pc_q <= pc_q;
      fetch_port_q <= !(state_q == ST_IDLE && tbl_req.valid) && !prog_rd_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_addr <= RESET_VECTOR;
      fetch_word <= 16'h0000;
    end else if (fetch_port_q) begin
      fetch_addr <= fetch_pc_q;
      fetch_word <= rom_data;
    end
  end

  // Pointers change only on explicit core writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_lo <= 8'h00;
      ptr_hi <= 8'h00;
    end else begin
      if (ptr_lo_we) ptr_lo <= ptr_wdata;
      if (ptr_hi_we) ptr_hi <= {2'h0, ptr_wdata[PTR_HI_W-1:0]};
    end
  end

  // Two-cycle sequence: address out, then data back
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      req_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (tbl_req.valid) begin
            state_q <= ST_FETCH;
            req_q <= tbl_req;
          end
        end
        ST_FETCH: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tbl_busy <= 1'b0;
    end else begin
      tbl_busy <= (state_q == ST_IDLE && tbl_req.valid);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tbl_wb <= '0;
    end else if (state_q == ST_FETCH) begin
      tbl_wb.valid <= 1'b1;
      tbl_wb.any_sector <= req_q.any_sector;
      tbl_wb.dest_addr <= req_q.dest_addr;
      tbl_wb.data <= rom_data[7:0];
    end else begin
      tbl_wb <= '0;
    end
  end

  // A table read wins over a software write in the same cycle
  // Software must save this around interrupt table reads
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_high_byte_holder <= HOLDER_RESET;
    end else if (state_q == ST_FETCH) begin
      table_high_byte_holder <= rom_data[15:8];
    end else if (holder_we) begin
      table_high_byte_holder <= holder_wdata;
    end
  end

  // Serial programming: idle bit, read flag, full address, data, MSB first
  logic pck_q;
  logic [PM_DW-1:0] prog_shift_q;
  logic [PM_DW-1:0] prog_shift_d;
  logic [4:0] prog_cnt_q;
  logic [4:0] prog_bit_idx;
  logic pck_rise;
  assign pck_rise = prog_mode && prog_serial_clock_line && !pck_q;
  assign prog_shift_d = {prog_shift_q[PM_DW-2:0], prog_serial_data_line_in};
  assign rom_we = pck_rise && prog_cnt_q == 5'(PROG_BITS - 1) && !prog_rd_q;
  assign rom_waddr = prog_addr_q;
  assign rom_wdata = prog_shift_d;
  // Data bit that the programmer samples at its next rising edge
  assign prog_bit_idx = 5'(PROG_BITS - 1) - prog_cnt_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pck_q <= 1'b0;
      prog_shift_q <= '0;
      prog_cnt_q <= 5'h00;
      prog_rd_q <= 1'b0;
      prog_addr_q <= '0;
    end else begin
      pck_q <= prog_serial_clock_line;
      if (!prog_mode) begin
        prog_cnt_q <= 5'h00;
        prog_rd_q <= 1'b0;
      end else if (pck_rise) begin
        prog_shift_q <= prog_shift_d;
        prog_cnt_q <= (prog_cnt_q == 5'(PROG_BITS - 1)) ? 5'h00 : prog_cnt_q + 5'h01;
        // Latching here gives the array the whole data phase to answer a read
        if (prog_cnt_q == 5'(PROG_BITS - PM_DW - 1)) begin
          prog_addr_q <= prog_shift_d[AW-1:0];
          prog_rd_q <= prog_shift_d[AW];
        end else if (prog_cnt_q == 5'(PROG_BITS - 1)) begin
          prog_rd_q <= 1'b0;
        end
      end
    end
  end

  // Read-back drives the shared line low-enable during the data phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_serial_data_line_out <= 1'b0;
      prog_serial_data_line_oe_n <= 1'b1;
    end else begin
      prog_serial_data_line_oe_n <= !(prog_mode && prog_rd_q);
      prog_serial_data_line_out <= prog_rd_q ? rom_data[prog_bit_idx[3:0]] : 1'b0;
    end
  end

  chk_read_two_cycles: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_IDLE && tbl_req.valid |-> ##2 tbl_wb.valid) else $error("write-back not two cycles later");
  chk_holder_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tbl_wb.valid |-> table_high_byte_holder == $past(rom_data[15:8])) else $error("holder not loaded");
  chk_low_byte: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tbl_wb.valid |-> tbl_wb.data == $past(rom_data[7:0])) else $error("low byte wrong");
  chk_ptr_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ptr_lo_we && !ptr_hi_we |=> $stable(ptr_lo) && $stable(ptr_hi)) else $error("pointer changed");
  chk_last_page: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_IDLE && tbl_req.valid && tbl_req.last_page |-> rom_addr[13:8] == LAST_PAGE_HI)
    else $error("last page not used");
  chk_paged_addr: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_IDLE && tbl_req.valid && !tbl_req.last_page |-> rom_addr == {ptr_hi[5:0], ptr_lo})
    else $error("paged address wrong");
  chk_sector_pass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == ST_IDLE && tbl_req.valid |-> ##2 tbl_wb.any_sector == $past(tbl_req.any_sector, 2))
    else $error("sector flag lost");
  chk_holder_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    holder_we && state_q != ST_FETCH |=> table_high_byte_holder == $past(holder_wdata))
    else $error("holder write lost");
  chk_reset_fetch: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> pc_q == RESET_VECTOR) else $error("fetch not at zero");
  cov_paged: cover property (@(posedge sys_clk) disable iff (!reset_n) tbl_wb.valid && !req_q.last_page);
  cov_last: cover property (@(posedge sys_clk) disable iff (!reset_n) tbl_req.valid && tbl_req.last_page);
  cov_ext: cover property (@(posedge sys_clk) disable iff (!reset_n) tbl_wb.valid && tbl_wb.any_sector);
  cov_prog: cover property (@(posedge sys_clk) disable iff (!reset_n) rom_we);
endmodule

// File: testbench/pmtr_core_model.sv
// Core-side data memory that takes table read write-backs
`timescale 1ns/10ps
module pmtr_core_model
  import pmtr_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Write-back from the table path
  input wire pmtr_wb_s tbl_wb,
  output int wr_count
);
  logic [7:0] dmem [2][512];
  initial wr_count = 0;
  // Core issues one read at a time, so the shared holder is never clobbered
  always @(posedge sys_clk) begin
    if (tbl_wb.valid === 1'b1) begin
      dmem[tbl_wb.any_sector][tbl_wb.dest_addr] = tbl_wb.data;
      wr_count = wr_count + 1;
    end
  end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the table read path
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  import pmtr_pkg::*;
  typedef struct packed {int at; logic [9:0] dest; logic [15:0] word; logic chk;} pmtr_note_s;
  logic sys_clk = 0, reset_n = 0, fetch_load = 0, fetch_step = 0, ptr_lo_we = 0, ptr_hi_we = 0;
  logic holder_we = 0, prog_mode = 0, pck = 0, pdi = 0, pdo, poe_n, busy;
  logic [13:0] fetch_target = 14'h0000, fetch_addr;
  logic [15:0] fetch_word;
  logic [7:0] ptr_wdata = 8'h00, holder_wdata = 8'h00, ptr_lo, ptr_hi, holder;
  pmtr_req_s tbl_req = '0;
  pmtr_wb_s tbl_wb;
  int miscompares = 0, total_checks = 0, cyc = 0, seed = 30, wr_count;
  logic [15:0] rom [4];
  logic [13:0] adr [4] = '{14'h0000, 14'h00ff, 14'h1100, 14'h3f06};
  logic [15:0] rdq;
  pmtr_note_s notes[$];
  pmtr_note_s n;

  pmtr_table_read pmtr_table_read_inst (.sys_clk(sys_clk), .reset_n(reset_n), .fetch_load(fetch_load),
    .fetch_target(fetch_target), .fetch_step(fetch_step), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
    .ptr_lo_we(ptr_lo_we), .ptr_hi_we(ptr_hi_we), .ptr_wdata(ptr_wdata), .ptr_lo(ptr_lo), .ptr_hi(ptr_hi),
    .tbl_req(tbl_req), .tbl_wb(tbl_wb), .tbl_busy(busy), .holder_we(holder_we), .holder_wdata(holder_wdata),
    .table_high_byte_holder(holder), .prog_mode(prog_mode), .prog_serial_clock_line(pck),
    .prog_serial_data_line_in(pdi), .prog_serial_data_line_out(pdo), .prog_serial_data_line_oe_n(poe_n));
  pmtr_core_model pmtr_core_model_inst (.sys_clk(sys_clk), .tbl_wb(tbl_wb), .wr_count(wr_count));

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc++;

  task automatic end_sim;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Serial clock rests low between frames; each level spans two system cycles
  task automatic prog_word(input logic rd, input logic [13:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] f;
    f = {1'b0, rd, a, d};
    q = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      pdi = f[i];
      repeat (2) @(negedge sys_clk);
      if (i < 16) q[i] = pdo;
      if (i == 0) `CHK(poe_n, !rd)
      pck = 1'b1;
      repeat (2) @(negedge sys_clk);
      pck = 1'b0;
    end
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    @(negedge sys_clk);
    ptr_hi_we = 1'b1;
    ptr_wdata = hi;
    @(negedge sys_clk);
    ptr_hi_we = 1'b0;
    ptr_lo_we = 1'b1;
    ptr_wdata = lo;
    @(negedge sys_clk);
    ptr_lo_we = 1'b0;
  endtask

  // Hold of three keeps valid up through the two refused edges
  task automatic tbl_read(input logic last, input logic any, input logic [8:0] dst, input logic [15:0] w,
                          input logic chk, input int hold);
    @(negedge sys_clk);
    tbl_req = '{1'b1, last, any, dst};
    notes.push_back('{cyc + 2, {any, dst}, w, chk});
    @(negedge sys_clk);
    `CHK(busy, 1'b1)
    repeat (hold - 1) @(negedge sys_clk);
    tbl_req.valid = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  always @(negedge sys_clk) begin
    if (tbl_wb.valid === 1'b1) begin
      n = notes.pop_front();
      `CHK(cyc, n.at)
      `CHK(busy, 1'b0)
      `CHK({tbl_wb.any_sector, tbl_wb.dest_addr}, n.dest)
      if (n.chk) begin
        `CHK(tbl_wb.data, n.word[7:0])
        `CHK(holder, n.word[15:8])
      end
    end
  end

  initial begin
    foreach (rom[i]) rom[i] = 16'($random(seed));
    repeat (12) @(negedge sys_clk);
    `CHK(fetch_addr, 14'h0000)
    reset_n = 1'b1;
    prog_mode = 1'b1;
    foreach (adr[i]) prog_word(1'b0, adr[i], rom[i], rdq);
    prog_word(1'b1, adr[2], 16'h0000, rdq);
    `CHK(rdq, rom[2])
    prog_mode = 1'b0;
    $display("test programming done");
    foreach (adr[i]) begin
      set_ptr({2'h3, adr[i][13:8]}, adr[i][7:0]);
      tbl_read(1'b0, i[0], 9'(i * 37), rom[i], 1'b1, (i == 3) ? 3 : 1);
      `CHK({ptr_hi, ptr_lo}, {2'h0, adr[i]})
    end
    $display("test paged reads done");
    set_ptr(8'h01, 8'h06);
    tbl_read(1'b1, 1'b1, 9'h1ff, rom[3], 1'b1, 1);
    `CHK({ptr_hi, ptr_lo}, 16'h0106)
    $display("test last page done");
    @(negedge sys_clk);
    holder_we = 1'b1;
    holder_wdata = 8'($random(seed));
    @(negedge sys_clk);
    holder_we = 1'b0;
    `CHK(holder, holder_wdata)
    fetch_load = 1'b1;
    @(negedge sys_clk);
    fetch_load = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK(fetch_addr, 14'h0000)
    `CHK(fetch_word, rom[0])
    fetch_step = 1'b1;
    @(negedge sys_clk);
    fetch_step = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK(fetch_addr, 14'h0001)
    `CHK(wr_count, 5)
    `CHK(notes.size(), 0)
    $display("test holder and fetch done");
    end_sim();
  end

  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule
